/* File: design/pwm_pkg.sv */
// Package for the 16-bit timer PWM block: register map, field positions,
// reset values, source codes, config structs and the channel state type.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package pwm_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_TIMER = 8'h08;
   localparam logic [7:0] ADDR_SRC0 = 8'h0C;
   localparam logic [7:0] ADDR_SRC1 = 8'h10;
   localparam logic [7:0] ADDR_SRC2 = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;
   // Field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_DIV_BIT = 1;
   localparam int EXT_ENABLE_BIT = 3;
   localparam int STAT_PWM_BIT = 0;
   localparam int STAT_RUN_BIT = 1;
   // Which timer channel this instance is (selects the select nibble)
   localparam logic [2:0] CHANNEL_INDEX = 3'h0;
   // Reset values
   localparam logic [15:0] TIMER_RST = 16'h0000;
   localparam logic [7:0] SRC_RST = 8'h00;
   localparam logic [1:0] MODE_RST = 2'h0;
   // Frame length in count-source periods: 2^16 - 1
   localparam logic [15:0] FRAME_LEN = 16'hFFFF;
   // Extended source codes
   localparam logic [2:0] SRC_DIV1 = 3'h0;
   localparam logic [2:0] SRC_DIV8 = 3'h1;
   localparam logic [2:0] SRC_DIV32 = 3'h2;
   localparam logic [2:0] SRC_DIV64 = 3'h3;
   localparam logic [2:0] SRC_SLOW = 3'h5;
   localparam logic [2:0] SRC_SUB = 3'h6;
   // Legacy clock pair codes
   localparam logic [1:0] LEG_DIV1 = 2'h0;
   localparam logic [1:0] LEG_DIV8 = 2'h1;
   localparam logic [1:0] LEG_DIV32 = 2'h2;
   localparam logic [1:0] LEG_SUB = 2'h3;
   // Subclock divide-by-32 terminal count
   localparam logic [4:0] SUB_LAST = 5'h1F;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic divider_bit;
      logic count_start;
   } ctrl_t;

   typedef struct packed {
      logic peripheral_divider_bit;
      logic extended_select_enable;
      logic [2:0] extended_source_code;
      logic [1:0] legacy_source;
   } src_cfg_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARMED = 2'b01,
      ST_RUN = 2'b10
   } pwm_state_t;
endpackage : pwm_pkg

/* File: design/source_tick.sv */
// Count-source selector: turns the chosen source into a one-cycle tick.
// Assumes clk is the undivided timer clock; subclock and slow oscillator
// arrive as asynchronous pins and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module source_tick
   import pwm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Selection
   input wire src_cfg_t cfg,
   // Asynchronous source pins
   input wire logic subclock_in,
   input wire logic slow_osc_in,
   // Selected count-source tick
   output logic tick
);
   logic [5:0] pre_reg;
   logic [2:0] sub_sync_reg;
   logic [2:0] osc_sync_reg;
   logic [4:0] sub_cnt_reg;
   // Edges are taken from the second and third stages only
   wire sub_rise = sub_sync_reg[1] & ~sub_sync_reg[2];
   wire osc_rise = osc_sync_reg[1] & ~osc_sync_reg[2];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pre_reg <= 6'h00;
         sub_sync_reg <= 3'h0;
         osc_sync_reg <= 3'h0;
         sub_cnt_reg <= 5'h00;
      end else begin
         pre_reg <= pre_reg + 6'h01;
         sub_sync_reg <= {sub_sync_reg[1:0], subclock_in};
         osc_sync_reg <= {osc_sync_reg[1:0], slow_osc_in};
         if (sub_rise) begin
            sub_cnt_reg <= sub_cnt_reg + 5'h01;
         end
      end
   end

   // RQ10 undivided or halved base
   wire t_base = cfg.peripheral_divider_bit ? 1'b1 : pre_reg[0];
   wire t_div8 = pre_reg[2:0] == 3'h7;
   wire t_div32 = pre_reg[4:0] == 5'h1F;
   wire t_div64 = pre_reg == 6'h3F;
   wire t_sub = sub_rise && (sub_cnt_reg == SUB_LAST);
   wire [1:0] leg = cfg.legacy_source;
   wire [2:0] ext = cfg.extended_source_code;
   // RQ8 legacy source pair
   wire t_leg = (leg == LEG_DIV1) ? t_base : (leg == LEG_DIV8) ? t_div8 :
                (leg == LEG_DIV32) ? t_div32 : t_sub;
   // RQ8 extended codes; unlisted codes stop the count
   wire t_ext = (ext == SRC_DIV1) ? t_base : (ext == SRC_DIV8) ? t_div8 :
                (ext == SRC_DIV32) ? t_div32 : (ext == SRC_DIV64) ? t_div64 :
                (ext == SRC_SLOW) ? osc_rise : (ext == SRC_SUB) ? t_sub : 1'b0;
   assign tick = cfg.extended_select_enable ? t_ext : t_leg;
   wire half_cfg = !cfg.extended_select_enable && leg == LEG_DIV1 && !cfg.peripheral_divider_bit;

   a_div8_select: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
      (cfg.extended_select_enable && ext == SRC_DIV8) |-> tick == (pre_reg[2:0] == 3'h7))
      else $error("div8 source ticks at wrong rate");
   a_half_base: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
      (half_cfg && tick) ##1 half_cfg |-> !tick)
      else $error("halved base source not at half rate");
endmodule : source_tick
`default_nettype wire

/* File: design/timer_pwm_16bit.sv */
// 16-bit PWM timer channel with an AXI4-Lite register slave and interrupt.
// Assumes trigger and source pins are asynchronous to clk.
// Contract
// RQ1: Trigger rise while started begins count, output high
// RQ2: Output falls when high time elapses
// RQ3: Falling output sets interrupt request bit
// RQ4: Reload register loaded each frame, counting continues
// RQ5: Clearing start stops, holds count, output low
// RQ6: Frame 2^16-1 periods, high n periods
// RQ7: Timer zero keeps output low, no interrupt
// RQ8: Source chosen by legacy pair or extended code
// RQ9: Channel takes its nibble from shared select
// RQ10: Divider bit picks undivided or halved base
// RQ11: 16-bit variant, active-high output pulse
// RQ12: Changes on source ticks; trigger synchronised first
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_16bit
   import pwm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins
   input wire logic trigger_input,
   input wire logic subclock_in,
   input wire logic slow_osc_in,
   output logic pwm_output,
   output logic irq
);
   ctrl_t ctrl_reg;
   logic [1:0] channel_mode_reg;
   logic [15:0] reload_reg;
   logic [7:0] source_select_reg0;
   logic [7:0] source_select_reg1;
   logic [3:0] source_select_reg2;
   logic irq_en_reg;
   logic irq_stat_reg;
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   pwm_state_t state_reg, state_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [15:0] frame_reg, frame_next;
   logic [15:0] n_run_reg, n_run_next;
   logic pwm_reg, pwm_next;
   logic pend_reg, pend_next;
   logic [2:0] trig_sync_reg;
   logic [15:0] hi_len_reg;
   logic tick;

   function automatic logic known(input logic [7:0] a);
      known = (a == ADDR_CTRL) || (a == ADDR_MODE) || (a == ADDR_TIMER) ||
              (a == ADDR_SRC0) || (a == ADDR_SRC1) || (a == ADDR_SRC2) ||
              (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_CLR) ||
              (a == ADDR_IRQ_EN) || (a == ADDR_STATUS);
   endfunction : known

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            merge[8*i +: 8] = d[8*i +: 8];
         end
      end
   endfunction : merge

   // Register readback; the timer address shows the live counter
   function automatic logic [31:0] word(input logic [7:0] a);
      case (a)
         ADDR_CTRL: word = {30'h0, ctrl_reg};
         ADDR_MODE: word = {30'h0, channel_mode_reg};
         ADDR_TIMER: word = {16'h0, cnt_reg};
         ADDR_SRC0: word = {24'h0, source_select_reg0};
         ADDR_SRC1: word = {24'h0, source_select_reg1};
         ADDR_SRC2: word = {28'h0, source_select_reg2};
         ADDR_IRQ_STAT: word = {31'h0, irq_stat_reg};
         ADDR_IRQ_EN: word = {31'h0, irq_en_reg};
         ADDR_STATUS: word = {30'h0, state_reg == ST_RUN, pwm_reg};
         default: word = 32'h0000_0000;
      endcase
   endfunction : word

   // Bus handshakes
   assign s_axi_awready = !aw_hold_reg;
   assign s_axi_wready = !w_hold_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   wire wr_do = aw_hold_reg && w_hold_reg && !bvalid_reg;
   wire rd_do = s_axi_arvalid && !rvalid_reg;
   wire [31:0] wr_val = merge(word(aw_addr_reg), w_data_reg, w_strb_reg);
   wire wr_ctrl = wr_do && aw_addr_reg == ADDR_CTRL;
   wire wr_timer = wr_do && aw_addr_reg == ADDR_TIMER;
   wire wr_clr = wr_do && aw_addr_reg == ADDR_IRQ_CLR && wr_val[0];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_hold_reg) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_hold_reg <= 1'b0;
         end
         if (s_axi_wvalid && !w_hold_reg) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (wr_do) begin
            w_hold_reg <= 1'b0;
         end
         if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= known(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end else if (rd_do) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= word(s_axi_araddr);
         rresp_reg <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Configuration registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_reg <= '0;
         channel_mode_reg <= MODE_RST;
         reload_reg <= TIMER_RST;
         source_select_reg0 <= SRC_RST;
         source_select_reg1 <= SRC_RST;
         source_select_reg2 <= SRC_RST[3:0];
         irq_en_reg <= 1'b0;
      end else if (wr_do) begin
         case (aw_addr_reg)
            ADDR_CTRL: ctrl_reg <= wr_val[1:0];
            ADDR_MODE: channel_mode_reg <= wr_val[1:0];
            ADDR_TIMER: reload_reg <= wr_val[15:0];
            ADDR_SRC0: source_select_reg0 <= wr_val[7:0];
            ADDR_SRC1: source_select_reg1 <= wr_val[7:0];
            ADDR_SRC2: source_select_reg2 <= wr_val[3:0];
            ADDR_IRQ_EN: irq_en_reg <= wr_val[0];
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // RQ9 nibble of the shared select register for this channel
   wire [7:0] sel_byte = (CHANNEL_INDEX[2:1] == 2'h0) ? source_select_reg0 :
                         (CHANNEL_INDEX[2:1] == 2'h1) ? source_select_reg1 :
                         {4'h0, source_select_reg2};
   wire [3:0] sel_nib = CHANNEL_INDEX[0] ? sel_byte[7:4] : sel_byte[3:0];
   src_cfg_t src_cfg;
   assign src_cfg = {ctrl_reg.divider_bit, sel_nib[EXT_ENABLE_BIT], sel_nib[2:0],
                     channel_mode_reg};

   source_tick u_tick (
      .clk(clk),
      .rst_n(rst_n),
      .cfg(src_cfg),
      .subclock_in(subclock_in),
      .slow_osc_in(slow_osc_in),
      .tick(tick)
   );

   // RQ12 trigger synchronised, edge taken past the first stage
   wire trig_rise = trig_sync_reg[1] & ~trig_sync_reg[2];
   wire start = ctrl_reg.count_start;
   wire running = state_reg == ST_RUN;
   wire frame_end = running && start && tick && frame_reg == 16'h0001;
   // RQ3 high time elapsed within a running frame
   wire fall_evt = running && start && tick && pwm_reg && cnt_reg == 16'h0001;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      frame_next = frame_reg;
      n_run_next = n_run_reg;
      pwm_next = pwm_reg;
      pend_next = pend_reg;
      case (state_reg)
         ST_IDLE: begin
            pwm_next = 1'b0;
            pend_next = 1'b0;
            if (wr_timer) begin
               cnt_next = wr_val[15:0];
            end
            if (start) begin
               state_next = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (wr_timer) begin
               cnt_next = wr_val[15:0];
            end
            if (!start) begin
               state_next = ST_IDLE;
            end else if (pend_reg && tick) begin
               // RQ1 RQ11 start on a source tick, active-high pulse
               state_next = ST_RUN;
               pend_next = 1'b0;
               cnt_next = reload_reg;
               n_run_next = reload_reg;
               frame_next = FRAME_LEN;
               // RQ7 zero keeps output low
               pwm_next = reload_reg != 16'h0000;
            end else if (trig_rise) begin
               pend_next = 1'b1;
            end
         end
         ST_RUN: begin
            if (!start) begin
               // RQ5 stop, hold count, drive low
               state_next = ST_IDLE;
               pwm_next = 1'b0;
            end else if (frame_end) begin
               // RQ4 RQ6 reload after 2^16-1 periods
               frame_next = FRAME_LEN;
               cnt_next = reload_reg;
               n_run_next = reload_reg;
               pwm_next = reload_reg != 16'h0000;
            end else if (tick) begin
               frame_next = frame_reg - 16'h0001;
               if (cnt_reg != 16'h0000) begin
                  cnt_next = cnt_reg - 16'h0001;
               end
               // RQ2 fall after n periods
               if (fall_evt) begin
                  pwm_next = 1'b0;
               end
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         cnt_reg <= TIMER_RST;
         frame_reg <= FRAME_LEN;
         n_run_reg <= TIMER_RST;
         pwm_reg <= 1'b0;
         pend_reg <= 1'b0;
         trig_sync_reg <= 3'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         frame_reg <= frame_next;
         n_run_reg <= n_run_next;
         pwm_reg <= pwm_next;
         pend_reg <= pend_next;
         trig_sync_reg <= {trig_sync_reg[1:0], trigger_input};
      end
   end

   // RQ3 sticky request; a new fall beats a same-cycle clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_stat_reg <= 1'b0;
      end else begin
         irq_stat_reg <= fall_evt | (irq_stat_reg & ~wr_clr);
      end
   end

   assign irq = irq_stat_reg & irq_en_reg;
   assign pwm_output = pwm_reg;

   // Ticks spent high in the current frame, for checking only
   always_ff @(posedge clk) begin
      if (!rst_n || !running || frame_end) begin
         hi_len_reg <= 16'h0000;
      end else if (tick && pwm_reg) begin
         hi_len_reg <= hi_len_reg + 16'h0001;
      end
   end

   sequence s_launch;
      state_reg == ST_ARMED && start && pend_reg && tick;
   endsequence
   sequence s_running_high(logic hi);
      running && pwm_reg == hi;
   endsequence

   a_trigger_start: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
      s_launch |=> s_running_high(n_run_reg != 16'h0000) ##0 cnt_reg == reload_reg)
      else $error("trigger did not start the pulse");
   a_high_width: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
      fall_evt |-> hi_len_reg + 16'h0001 == n_run_reg)
      else $error("high phase length differs from timer value");
   a_fall_low: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
      (fall_evt && frame_reg != 16'h0001) |=> !pwm_output)
      else $error("output did not fall after high time");
   a_fall_irq: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
      fall_evt |=> irq_stat_reg)
      else $error("fall did not set request bit");
   a_frame_reload: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
      frame_end |=> frame_reg == FRAME_LEN && cnt_reg == $past(reload_reg))
      else $error("frame end did not reload");
   a_stop_hold: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
      (running && !start) |=> !pwm_output && cnt_reg == $past(cnt_reg)
      ##1 state_reg != ST_RUN)
      else $error("stop did not hold count and drive low");
   a_zero_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
      (running && n_run_reg == 16'h0000) |-> !pwm_output && !fall_evt)
      else $error("zero timer produced a pulse");
   a_tick_only: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
      (running && start && !tick) |=> $stable(cnt_reg) && $stable(pwm_output))
      else $error("counter moved without a source tick");
endmodule : timer_pwm_16bit
`default_nettype wire

/* File: dv/trigger_load_model.sv */
// Far side of the PWM channel: trigger source, source oscillators, PWM load.
// Assumes it runs on the block clock; oscillators derive from clk so widths are exact.
`timescale 1ns/1ps
`default_nettype none
module trigger_load_model #(
   parameter int SLOW_DIV = 10,
   parameter int SUB_DIV = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Load side
   input wire logic pwm_output,
   // Source pins
   output logic trigger_input,
   output logic subclock_in,
   output logic slow_osc_in,
   // Measurements of the output
   output int last_high,
   output int last_period,
   output int falls
);
   int hi_cnt;
   int per_cnt;
   int osc_cnt;
   logic pwm_q;

   initial begin
      trigger_input = 1'b0;
      subclock_in = 1'b0;
      slow_osc_in = 1'b0;
      osc_cnt = 0;
      pwm_q = 1'b0;
   end

   always @(posedge clk) begin
      osc_cnt <= osc_cnt + 1;
      slow_osc_in <= (osc_cnt % SLOW_DIV) < (SLOW_DIV / 2);
      subclock_in <= (osc_cnt % SUB_DIV) < (SUB_DIV / 2);
   end

   // High time and rise-to-rise period of the load waveform
   always @(posedge clk) begin
      pwm_q <= pwm_output;
      if (!rst_n) begin
         hi_cnt <= 0;
         per_cnt <= 0;
         falls <= 0;
         last_high <= 0;
         last_period <= 0;
      end else begin
         per_cnt <= per_cnt + 1;
         if (pwm_output && !pwm_q) begin
            hi_cnt <= 1;
            per_cnt <= 1;
            last_period <= per_cnt;
         end else if (pwm_output) begin
            hi_cnt <= hi_cnt + 1;
         end
         if (!pwm_output && pwm_q) begin
            last_high <= hi_cnt;
            falls <= falls + 1;
         end
      end
   end

   task automatic fire;
      @(posedge clk);
      trigger_input <= 1'b1;
      repeat (4) @(posedge clk);
      trigger_input <= 1'b0;
   endtask : fire
endmodule : trigger_load_model
`default_nettype wire

/* File: dv/timer_pwm_16bit_tb.sv */
// Self-checking bench: register bus master, source model and pulse checks.
// Assumes the partner model drives the pins and measures the PWM output.
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_16bit_tb;
   import pwm_pkg::*;
   localparam int SLOW_DIV = 10;
   localparam int SUB_DIV = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, pwm, irq, trig, sub, slow;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [31:0] seed = 32'hE3F8;
   int last_high, last_period, falls, f0, n;
   int bad_count = 0;
   int n_checks = 0;
   logic r_dv[11] = '{1, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1};
   logic [1:0] r_md[11] = '{0, 0, 1, 2, 3, 0, 0, 0, 0, 0, 0};
   logic [3:0] r_nb[11] = '{0, 0, 0, 0, 0, 4'h8, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE};
   logic [7:0] regs[10] = '{ADDR_CTRL, ADDR_MODE, ADDR_TIMER, ADDR_SRC0, ADDR_SRC1,
      ADDR_SRC2, ADDR_IRQ_STAT, ADDR_IRQ_CLR, ADDR_IRQ_EN, ADDR_STATUS};

   always #25 clk = ~clk;

   timer_pwm_16bit timer_pwm_16bit_inst (.clk(clk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .trigger_input(trig), .subclock_in(sub), .slow_osc_in(slow), .pwm_output(pwm),
      .irq(irq));

   trigger_load_model #(.SLOW_DIV(SLOW_DIV), .SUB_DIV(SUB_DIV)) trigger_load_model_inst (
      .clk(clk), .rst_n(rst_n), .pwm_output(pwm), .trigger_input(trig), .subclock_in(sub),
      .slow_osc_in(slow), .last_high(last_high), .last_period(last_period), .falls(falls));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   // Model of the count-source period in clk cycles
   function automatic int src_div(input logic dv, input logic [1:0] md, input logic [3:0] nb);
      int base;
      base = dv ? 1 : 2;
      if (nb[3]) begin
         case (nb[2:0])
            3'h0: return base;
            3'h1: return 8;
            3'h2: return 32;
            3'h3: return 64;
            3'h5: return SLOW_DIV;
            default: return 32 * SUB_DIV;
         endcase
      end
      case (md)
         2'h0: return base;
         2'h1: return 8;
         2'h2: return 32;
         default: return 32 * SUB_DIV;
      endcase
   endfunction : src_div

   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk_word

   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit

   task automatic chk_count(input string nm, input int e, input int g);
      n_checks++;
      if (g != e) begin
         bad_count++;
         $display("BAD %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_count

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int t;
      t = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         t++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && t < 100);
      bready <= 1'b0;
      chk_bit("bvalid", 1'b1, bvalid);
      chk_word("bresp", {30'h0, er}, {30'h0, bresp});
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int t;
      t = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         t++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && t < 100);
      rready <= 1'b0;
      chk_bit("rvalid", 1'b1, rvalid);
      chk_word("rdata", ed, rdata);
      chk_word("rresp", {30'h0, er}, {30'h0, rresp});
   endtask : axi_rd

   task automatic wait_falls(input int target, input int lim);
      int t;
      t = 0;
      while (falls < target && t < lim) begin
         @(posedge clk);
         t++;
      end
      chk_count("falls", target, falls);
   endtask : wait_falls

   task automatic results;
      if (bad_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results

   initial begin
      repeat (95000) @(posedge clk);
      bad_count++;
      results();
   end

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      foreach (regs[i]) axi_rd(regs[i], 32'h0, RESP_OKAY);
      axi_rd(8'hFC, 32'h0, RESP_SLVERR);
      axi_wr(8'hFC, 32'hFFFFFFFF, RESP_SLVERR);
      axi_wr(ADDR_SRC1, 32'hA5, RESP_OKAY);
      axi_rd(ADDR_SRC1, 32'hA5, RESP_OKAY);
      // Trigger without the start flag must not run
      axi_wr(ADDR_TIMER, 32'h5, RESP_OKAY);
      trigger_load_model_inst.fire();
      repeat (40) @(posedge clk);
      chk_bit("pwm_output", 1'b0, pwm);
      axi_wr(ADDR_TIMER, 32'h0, RESP_OKAY);
      axi_wr(ADDR_CTRL, 32'h3, RESP_OKAY);
      trigger_load_model_inst.fire();
      repeat (300) @(posedge clk);
      chk_bit("pwm_output", 1'b0, pwm);
      chk_count("falls", 0, falls);
      axi_rd(ADDR_IRQ_STAT, 32'h0, RESP_OKAY);
      foreach (r_dv[r]) begin
         seed = xorshift(seed);
         n = int'(seed % 8) + 1;
         axi_wr(ADDR_CTRL, {30'h0, r_dv[r], 1'b0}, RESP_OKAY);
         axi_wr(ADDR_MODE, {30'h0, r_md[r]}, RESP_OKAY);
         // High nibble selects a silent source for the other channel
         axi_wr(ADDR_SRC0, {24'h0, 4'hF, r_nb[r]}, RESP_OKAY);
         axi_wr(ADDR_TIMER, n, RESP_OKAY);
         axi_wr(ADDR_IRQ_CLR, 32'h1, RESP_OKAY);
         axi_wr(ADDR_IRQ_EN, 32'h1, RESP_OKAY);
         f0 = falls;
         axi_wr(ADDR_CTRL, {30'h0, r_dv[r], 1'b1}, RESP_OKAY);
         trigger_load_model_inst.fire();
         wait_falls(f0 + 1, 3000);
         chk_count("high_time", n * src_div(r_dv[r], r_md[r], r_nb[r]), last_high);
         axi_rd(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
         chk_bit("irq", 1'b1, irq);
      end
      axi_wr(ADDR_IRQ_EN, 32'h0, RESP_OKAY);
      @(posedge clk);
      chk_bit("irq", 1'b0, irq);
      axi_wr(ADDR_IRQ_EN, 32'h1, RESP_OKAY);
      @(posedge clk);
      chk_bit("irq", 1'b1, irq);
      axi_wr(ADDR_IRQ_CLR, 32'h1, RESP_OKAY);
      axi_rd(ADDR_IRQ_STAT, 32'h0, RESP_OKAY);
      chk_bit("irq", 1'b0, irq);
      // Stop in the high phase, then restart without a trigger
      axi_wr(ADDR_CTRL, 32'h2, RESP_OKAY);
      axi_wr(ADDR_SRC0, 32'h0, RESP_OKAY);
      axi_wr(ADDR_MODE, 32'h0, RESP_OKAY);
      axi_wr(ADDR_TIMER, 32'hC8, RESP_OKAY);
      axi_wr(ADDR_CTRL, 32'h3, RESP_OKAY);
      trigger_load_model_inst.fire();
      repeat (10) @(posedge clk);
      axi_rd(ADDR_STATUS, 32'h3, RESP_OKAY);
      axi_wr(ADDR_CTRL, 32'h2, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk_bit("pwm_output", 1'b0, pwm);
      axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
      axi_rd(ADDR_TIMER, 201 - last_high, RESP_OKAY);
      axi_wr(ADDR_CTRL, 32'h3, RESP_OKAY);
      repeat (300) @(posedge clk);
      chk_bit("pwm_output", 1'b0, pwm);
      // One whole frame on the undivided source
      axi_wr(ADDR_CTRL, 32'h2, RESP_OKAY);
      axi_wr(ADDR_TIMER, 32'h3, RESP_OKAY);
      axi_wr(ADDR_CTRL, 32'h3, RESP_OKAY);
      f0 = falls;
      trigger_load_model_inst.fire();
      wait_falls(f0 + 2, 70000);
      chk_count("frame", int'(FRAME_LEN), last_period);
      chk_count("high_time", 3, last_high);
      results();
   end
endmodule : timer_pwm_16bit_tb
`default_nettype wire
